// file: crs_pkg.sv
package crs_pkg;

   localparam int          ACC_W        = 8;
   localparam int          TP_W         = 11;
   localparam int          PC_W         = 10;
   localparam int          SP_W         = 4;
   localparam int          FLAG_W       = 8;
   localparam int          MADDR_W      = 12;
   localparam int          BUS_AW       = 2;

   // Register bus offsets
   localparam logic [1:0]  OFS_TP_LO    = 2'h0;
   localparam logic [1:0]  OFS_TP_HI    = 2'h1;
   localparam logic [1:0]  OFS_SP       = 2'h2;
   localparam logic [1:0]  OFS_FLAGS    = 2'h3;

   // Flag word bit positions and table pointer space-select bit
   localparam int          FL_C         = 0;
   localparam int          FL_H         = 1;
   localparam int          FL_Z         = 2;
   localparam int          FL_N         = 3;
   localparam int          FL_G         = 4;
   localparam int          FL_R         = 5;
   localparam int          TP_SEL       = 10;

   // Reset values and fixed addresses
   localparam logic [7:0]  ACC_RST      = 8'h00;
   localparam logic [10:0] TP_RST       = 11'h000;
   localparam logic [11:0] PC_RST       = 12'hC00;
   localparam logic [3:0]  SP_RST       = 4'hF;
   localparam logic [7:0]  STACK_BASE   = 8'h30;
   localparam logic [1:0]  PROG_PAGE    = 2'h3;
   localparam logic [1:0]  DATA_PAGE    = 2'h0;

   typedef enum logic [4:0] {
      CRS_OP_NONE,
      CRS_OP_LOAD,
      CRS_OP_ADC,
      CRS_OP_SUBC,
      CRS_OP_AND,
      CRS_OP_XOR,
      CRS_OP_RLC,
      CRS_OP_RRC,
      CRS_OP_SET_C,
      CRS_OP_CLR_C,
      CRS_OP_TOGGLE_CARRY,
      CRS_OP_LDC,
      CRS_OP_SET_G,
      CRS_OP_CLR_G,
      CRS_OP_LOAD_TP,
      CRS_OP_INDEX,
      CRS_OP_STORE_X,
      CRS_OP_ADVANCE,
      CRS_OP_JUMP,
      CRS_OP_CALL,
      CRS_OP_RET
   } crs_op_type;

   typedef struct packed {
      crs_op_type       op;
      logic [7:0]       operand;
      logic [9:0]       target;
      logic [2:0]       bit_sel;
   } crs_cmd_type;

   typedef struct packed {
      logic [7:0]       addr;
      logic [7:0]       wdata;
      logic             we;
      logic             re;
   } crs_stack_type;

   typedef struct packed {
      logic [11:0]      addr;
      logic [7:0]       wdata;
      logic             we;
   } crs_mem_type;

endpackage : crs_pkg

// file: crs_register_set.sv
`timescale 1ns/1ns
// Summary of operation
// [RULE1] Eight-bit accumulator holds operands and results of ALU and data moves.
// [RULE2] Effective address is table pointer plus an eight-bit unsigned offset.
// [RULE3] Stores through the pointer into program space never reach code memory.
// [RULE4] Low ten pointer bits give the location inside the chosen space.
// [RULE5] Pointer top bit is write-only; 0 selects data, 1 selects program space.
// [RULE6] Ten-bit program counter; reset loads the start address 0xC00.
// [RULE7] Four-bit stack pointer places the call stack within 0x30 to 0x3F.
// [RULE8] Any reset sets the stack pointer to 0xF, next free slot 0x3F.
// [RULE9] Stack grows down: minus two per push, plus two per pull.
// [RULE10] A call pushes the return address automatically, low byte first.
// [RULE11] A return pulls the address into the program counter and resumes there.
// [RULE12] Eight-bit flag word: carry, half carry, zero, sign, mask and write flag.
// [RULE13] Carry is set by ALU carry or borrow and by its own instructions.
// [RULE14] Rotates pass through carry: out bit enters carry, old carry enters operand.
// [RULE15] Load-carry copies a chosen bit into carry; toggle-carry inverts it.
// [RULE16] Half carry reports a carry between accumulator nibbles.
// [RULE17] Zero flag is set for a zero result and cleared otherwise.
// [RULE18] Pointer, stack pointer and flag word are memory mapped; others internal.
// [RULE19] Sign flag follows the most significant bit of the result.
// [RULE20] Interrupt mask reads cleared after reset; only software sets it.
// [RULE21] Write-busy flag is a status input from the data memory writer.
module crs_register_set (
   input  wire logic                clk,
   input  wire logic                resetn,
   input  wire crs_pkg::crs_cmd_type cmd,
   output logic                     busy,
   input  wire logic [1:0]          bus_addr,
   input  wire logic [7:0]          bus_wdata,
   input  wire logic                bus_wr,
   input  wire logic                bus_rd,
   output logic [7:0]               bus_rdata,
   input  wire logic                mem_busy_bit,
   output crs_pkg::crs_stack_type   stack_bus,
   input  wire logic [7:0]          stack_rdata,
   output crs_pkg::crs_mem_type     index_bus,
   output logic [7:0]               acc,
   output logic [9:0]               instr_pointer,
   output logic [3:0]               stack_top_index,
   output logic [7:0]               flag_word
);

   typedef enum logic [2:0] {
      CRS_IDLE,
      CRS_PUSH_HI,
      CRS_RD_LO,
      CRS_RD_HI,
      CRS_FINISH
   } crs_seq_type;

   typedef struct packed {
      logic [7:0]             acc;
      logic [10:0]            tp;
      logic [9:0]             pc;
      logic [3:0]             sp;
      logic                   c;
      logic                   h;
      logic                   z;
      logic                   n;
      logic                   g;
      logic                   r;
      crs_seq_type            seq;
      logic                   bsy;
      logic [1:0]             ret_hi;
      logic [7:0]             ret_lo;
      logic [7:0]             rdata;
      crs_pkg::crs_stack_type stk;
      crs_pkg::crs_mem_type   mem;
   } crs_state_type;

   crs_state_type state;
   crs_state_type next_state;

   function automatic logic [7:0] crs_flag_pack(input crs_state_type s);
      logic [7:0] f;
      f = 8'h00;
      f[crs_pkg::FL_C] = s.c;
      f[crs_pkg::FL_H] = s.h;
      f[crs_pkg::FL_Z] = s.z;
      f[crs_pkg::FL_N] = s.n;
      f[crs_pkg::FL_G] = s.g;
      f[crs_pkg::FL_R] = s.r;
      return f;
   endfunction : crs_flag_pack

   always_comb begin
      logic [8:0]  sum9;
      logic [4:0]  nib5;
      logic [7:0]  res;
      logic        upd_zn;
      logic [9:0]  ea10;
      sum9   = 9'h000;
      nib5   = 5'h00;
      res    = state.acc;
      upd_zn = 1'b0;
      ea10   = 10'h000;
      next_state = state;
      next_state.stk.we = 1'b0;
      next_state.stk.re = 1'b0;
      next_state.mem.we = 1'b0;
      next_state.rdata  = 8'h00;
      next_state.r      = mem_busy_bit; // RULE21

      // Register bus read, data one cycle later
      if (bus_rd) begin
         case (bus_addr)
            crs_pkg::OFS_TP_LO: next_state.rdata = state.tp[7:0]; // RULE18
            crs_pkg::OFS_TP_HI: next_state.rdata = {6'h00, state.tp[9:8]}; // RULE5
            crs_pkg::OFS_SP:    next_state.rdata = {4'h0, state.sp}; // RULE18
            crs_pkg::OFS_FLAGS: next_state.rdata = crs_flag_pack(state); // RULE18
            default:            next_state.rdata = 8'h00;
         endcase
      end

      // Register bus write, applied before core updates so hardware wins
      if (bus_wr) begin
         case (bus_addr)
            crs_pkg::OFS_TP_LO: next_state.tp[7:0] = bus_wdata;
            crs_pkg::OFS_TP_HI: next_state.tp[10:8] = bus_wdata[2:0]; // RULE5
            crs_pkg::OFS_SP:    next_state.sp = bus_wdata[3:0]; // RULE7
            crs_pkg::OFS_FLAGS: begin
               next_state.c = bus_wdata[crs_pkg::FL_C];
               next_state.h = bus_wdata[crs_pkg::FL_H];
               next_state.z = bus_wdata[crs_pkg::FL_Z];
               next_state.n = bus_wdata[crs_pkg::FL_N];
               next_state.g = bus_wdata[crs_pkg::FL_G]; // RULE20
            end
            default: ;
         endcase
      end

      case (state.seq)
         CRS_IDLE: begin
            case (cmd.op)
               crs_pkg::CRS_OP_LOAD: begin
                  res    = cmd.operand; // RULE1
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_ADC: begin
                  sum9   = {1'b0, state.acc} + {1'b0, cmd.operand} + {8'h00, state.c};
                  nib5   = {1'b0, state.acc[3:0]} + {1'b0, cmd.operand[3:0]}
                         + {4'h0, state.c};
                  res    = sum9[7:0]; // RULE1
                  next_state.c = sum9[8]; // RULE13
                  next_state.h = nib5[4]; // RULE16
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_SUBC: begin
                  sum9   = {1'b0, state.acc} - {1'b0, cmd.operand} - {8'h00, state.c};
                  nib5   = {1'b0, state.acc[3:0]} - {1'b0, cmd.operand[3:0]}
                         - {4'h0, state.c};
                  res    = sum9[7:0];
                  next_state.c = sum9[8]; // RULE13
                  next_state.h = nib5[4]; // RULE16
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_AND: begin
                  res    = state.acc & cmd.operand;
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_XOR: begin
                  res    = state.acc ^ cmd.operand;
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_RLC: begin
                  res    = {state.acc[6:0], state.c}; // RULE14
                  next_state.c = state.acc[7]; // RULE14
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_RRC: begin
                  res    = {state.c, state.acc[7:1]}; // RULE14
                  next_state.c = state.acc[0]; // RULE14
                  upd_zn = 1'b1;
               end
               crs_pkg::CRS_OP_SET_C: next_state.c = 1'b1; // RULE13
               crs_pkg::CRS_OP_CLR_C: next_state.c = 1'b0; // RULE13
               crs_pkg::CRS_OP_TOGGLE_CARRY:  next_state.c = ~state.c; // RULE15
               crs_pkg::CRS_OP_LDC:   next_state.c = cmd.operand[cmd.bit_sel]; // RULE15
               crs_pkg::CRS_OP_SET_G: next_state.g = 1'b1; // RULE20
               crs_pkg::CRS_OP_CLR_G: next_state.g = 1'b0;
               crs_pkg::CRS_OP_LOAD_TP: begin
                  next_state.tp = {cmd.target[2:0], cmd.operand}; // RULE5
               end
               crs_pkg::CRS_OP_INDEX, crs_pkg::CRS_OP_STORE_X: begin
                  ea10 = state.tp[9:0] + {2'h0, cmd.operand}; // RULE2 RULE4
                  next_state.mem.addr = state.tp[crs_pkg::TP_SEL]
                     ? {crs_pkg::PROG_PAGE, ea10} : {crs_pkg::DATA_PAGE, ea10}; // RULE5
                  next_state.mem.wdata = state.acc;
                  next_state.mem.we = (cmd.op == crs_pkg::CRS_OP_STORE_X)
                     && !state.tp[crs_pkg::TP_SEL]; // RULE3
               end
               crs_pkg::CRS_OP_ADVANCE: next_state.pc = state.pc + 10'h001; // RULE6
               crs_pkg::CRS_OP_JUMP:    next_state.pc = cmd.target;
               crs_pkg::CRS_OP_CALL: begin
                  next_state.stk.addr  = crs_pkg::STACK_BASE + {4'h0, state.sp}; // RULE7
                  next_state.stk.wdata = state.pc[7:0]; // RULE10
                  next_state.stk.we    = 1'b1; // RULE10
                  next_state.ret_hi    = state.pc[9:8];
                  next_state.pc        = cmd.target;
                  next_state.seq       = CRS_PUSH_HI;
               end
               crs_pkg::CRS_OP_RET: begin
                  next_state.stk.addr = crs_pkg::STACK_BASE
                     + {4'h0, 4'(state.sp + 4'h2)}; // RULE11
                  next_state.stk.re   = 1'b1;
                  next_state.seq      = CRS_RD_LO;
               end
               default: ;
            endcase
            if (upd_zn) begin
               next_state.acc = res; // RULE1
               next_state.z   = (res == 8'h00); // RULE17
               next_state.n   = res[7]; // RULE19
            end
         end
         CRS_PUSH_HI: begin
            next_state.stk.addr  = crs_pkg::STACK_BASE
               + {4'h0, 4'(state.sp - 4'h1)};
            next_state.stk.wdata = {6'h00, state.ret_hi}; // RULE10
            next_state.stk.we    = 1'b1;
            next_state.sp        = state.sp - 4'h2; // RULE9
            next_state.seq       = CRS_IDLE;
         end
         CRS_RD_LO: begin
            next_state.stk.addr = crs_pkg::STACK_BASE
               + {4'h0, 4'(state.sp + 4'h1)};
            next_state.stk.re   = 1'b1;
            next_state.seq      = CRS_RD_HI;
         end
         CRS_RD_HI: begin
            next_state.ret_lo = stack_rdata;
            next_state.seq    = CRS_FINISH;
         end
         CRS_FINISH: begin
            next_state.pc  = {stack_rdata[1:0], state.ret_lo}; // RULE11
            next_state.sp  = state.sp + 4'h2; // RULE9
            next_state.seq = CRS_IDLE;
         end
         default: next_state.seq = CRS_IDLE;
      endcase
      // Busy comes from its own flop so the output is registered
      next_state.bsy = (next_state.seq != CRS_IDLE);
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state        <= '0;
         state.acc    <= crs_pkg::ACC_RST;
         state.tp     <= crs_pkg::TP_RST;
         state.pc     <= crs_pkg::PC_RST[9:0]; // RULE6
         state.sp     <= crs_pkg::SP_RST; // RULE8
         state.g      <= 1'b0; // RULE20
         state.seq    <= CRS_IDLE;
         state.bsy    <= 1'b0;
      end else begin
         state <= next_state;
      end
   end

   assign busy            = state.bsy;
   assign bus_rdata       = state.rdata;
   assign stack_bus       = state.stk;
   assign index_bus       = state.mem;
   assign acc             = state.acc;
   assign instr_pointer   = state.pc;
   assign stack_top_index = state.sp;
   assign flag_word       = crs_flag_pack(state); // RULE12

endmodule : crs_register_set

// file: crs_monitor.sv
`timescale 1ns/1ns
module crs_monitor (
   input wire logic                  clk,
   input wire logic                  resetn,
   input wire crs_pkg::crs_cmd_type  cmd,
   input wire logic                  busy,
   input wire logic [1:0]            bus_addr,
   input wire logic [7:0]            bus_wdata,
   input wire logic                  bus_wr,
   input wire logic                  bus_rd,
   input wire logic [7:0]            bus_rdata,
   input wire logic                  mem_busy_bit,
   input wire crs_pkg::crs_stack_type stack_bus,
   input wire logic [7:0]            stack_rdata,
   input wire crs_pkg::crs_mem_type  index_bus,
   input wire logic [7:0]            acc,
   input wire logic [9:0]            instr_pointer,
   input wire logic [3:0]            stack_top_index,
   input wire logic [7:0]            flag_word
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!resetn);

   sequence s_push;
      busy && stack_bus.we && stack_bus.addr == {4'h3, stack_top_index} ##1
      !busy && stack_bus.we && stack_bus.addr == {4'h3, stack_top_index + 4'h1} &&
      stack_top_index == $past(stack_top_index) - 4'h2;
   endsequence
   sequence s_pull;
      busy && stack_bus.re && stack_bus.addr == {4'h3, stack_top_index + 4'h2} ##1
      busy && stack_bus.re && stack_bus.addr == {4'h3, stack_top_index + 4'h1};
   endsequence

   a_reset_values: assert property ($rose(resetn) |-> stack_top_index == 4'hF &&
      flag_word == 8'h00 && instr_pointer == 10'h000 && acc == 8'h00 && !busy)
      else $error("state after reset wrong");
   a_call_push: assert property (!busy && cmd.op == crs_pkg::CRS_OP_CALL |=> s_push
      ##1 !busy)
      else $error("call push sequence wrong");
   a_ret_pull: assert property (!busy && cmd.op == crs_pkg::CRS_OP_RET |=> s_pull
      ##2 (!busy && stack_top_index == $past(stack_top_index) + 4'h2))
      else $error("return pull sequence wrong");
   a_rdata_idle: assert property ($past(resetn) && !$past(bus_rd) |-> bus_rdata == 8'h00)
      else $error("read data outside read cycle");
   a_read_sp: assert property (bus_rd && bus_addr == crs_pkg::OFS_SP |=>
      bus_rdata[3:0] == $past(stack_top_index))
      else $error("stack pointer readback wrong");
   a_read_flags: assert property (bus_rd && bus_addr == crs_pkg::OFS_FLAGS |=>
      bus_rdata == $past(flag_word))
      else $error("flag word readback wrong");
   a_store_page: assert property (index_bus.we |-> index_bus.addr[11:10] == 2'h0 &&
      $past(cmd.op) == crs_pkg::CRS_OP_STORE_X)
      else $error("indexed store outside data space");
   a_load_flags: assert property (!busy && cmd.op == crs_pkg::CRS_OP_LOAD |=>
      acc == $past(cmd.operand) && flag_word[2] == ($past(cmd.operand) == 8'h00) &&
      flag_word[3] == $past(cmd.operand[7]))
      else $error("load result or flags wrong");
   a_busy_status: assert property ($past(resetn) |-> flag_word[5] == $past(mem_busy_bit))
      else $error("write flag does not follow status");
endmodule : crs_monitor

bind crs_register_set crs_monitor mon_u (.clk(clk), .resetn(resetn), .cmd(cmd), .busy(busy),
   .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
   .bus_rdata(bus_rdata), .mem_busy_bit(mem_busy_bit), .stack_bus(stack_bus),
   .stack_rdata(stack_rdata), .index_bus(index_bus), .acc(acc), .instr_pointer(instr_pointer),
   .stack_top_index(stack_top_index), .flag_word(flag_word));

// file: tb_crs_register_set.sv
`timescale 1ns/1ns
module tb_crs_register_set;
   logic                   clk;
   logic                   resetn;
   crs_pkg::crs_cmd_type   cmd;
   logic                   busy;
   logic [1:0]             bus_addr;
   logic [7:0]             bus_wdata;
   logic                   bus_wr;
   logic                   bus_rd;
   logic [7:0]             bus_rdata;
   logic                   mem_busy_bit;
   crs_pkg::crs_stack_type stack_bus;
   logic [7:0]             stack_rdata;
   crs_pkg::crs_mem_type   index_bus;
   logic [7:0]             acc;
   logic [9:0]             instr_pointer;
   logic [3:0]             stack_top_index;
   logic [7:0]             flag_word;
   logic [7:0]             stack_mem [256];
   logic [15:0]            push_log [$];
   logic [7:0]             rd;
   int                     miscompares;
   int                     check_count;
   int                     cycles;

   crs_register_set dut_u (.clk(clk), .resetn(resetn), .cmd(cmd), .busy(busy),
      .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
      .bus_rdata(bus_rdata), .mem_busy_bit(mem_busy_bit), .stack_bus(stack_bus),
      .stack_rdata(stack_rdata), .index_bus(index_bus), .acc(acc),
      .instr_pointer(instr_pointer), .stack_top_index(stack_top_index), .flag_word(flag_word));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Stack memory: answers the cycle after a read, otherwise shows a changing pattern
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 4000) begin
         miscompares++;
         print_verdict();
      end
      if (stack_bus.we === 1'b1) begin
         stack_mem[stack_bus.addr] <= stack_bus.wdata;
         push_log.push_back({stack_bus.addr, stack_bus.wdata});
      end
      stack_rdata <= (stack_bus.re === 1'b1) ? stack_mem[stack_bus.addr] : ~stack_rdata;
   end

   task automatic print_verdict();
      if (miscompares == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         miscompares++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic bus_w(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus_addr  <= a;
      bus_wdata <= d;
      bus_wr    <= 1'b1;
      @(posedge clk);
      bus_wr    <= 1'b0;
      #1;
   endtask : bus_w

   task automatic bus_r(input logic [1:0] a);
      @(posedge clk);
      bus_addr <= a;
      bus_rd   <= 1'b1;
      @(posedge clk);
      bus_rd   <= 1'b0;
      #1;
      rd = bus_rdata;
   endtask : bus_r

   task automatic run_op(input crs_pkg::crs_op_type o, input logic [7:0] d,
                         input logic [9:0] t, input logic [2:0] b);
      @(posedge clk);
      cmd <= '{op: o, operand: d, target: t, bit_sel: b};
      @(posedge clk);
      cmd <= '0;
      #1;
   endtask : run_op

   task automatic step(input crs_pkg::crs_op_type o, input logic [7:0] d, input logic [2:0] b,
                       input logic [7:0] ea, input logic [7:0] ef);
      run_op(o, d, 10'h000, b);
      chk(acc, ea);
      chk(flag_word, ef);
   endtask : step

   task automatic wait_idle();
      for (int i = 0; i < 20 && busy !== 1'b0; i++) begin
         @(posedge clk);
         #1;
      end
      chk(busy, 1'b0);
   endtask : wait_idle

   initial begin
      resetn = 1'b0;
      cmd = '0;
      bus_addr = 2'h0;
      bus_wdata = 8'h00;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      mem_busy_bit = 1'b0;
      stack_rdata = 8'h00;
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      #1;
      chk(stack_top_index, crs_pkg::SP_RST);
      chk(instr_pointer, crs_pkg::PC_RST[9:0]);
      chk(flag_word, 8'h00);
      chk(acc, crs_pkg::ACC_RST);
      bus_r(crs_pkg::OFS_SP);
      chk(rd[3:0], 4'hF);
      bus_w(crs_pkg::OFS_TP_LO, 8'hA5);
      bus_w(crs_pkg::OFS_TP_HI, 8'h07);
      bus_r(crs_pkg::OFS_TP_LO);
      chk(rd, 8'hA5);
      bus_r(crs_pkg::OFS_TP_HI);
      chk(rd[2:0], 3'h3);
      bus_w(crs_pkg::OFS_SP, 8'h06);
      chk(stack_top_index, 4'h6);
      bus_w(crs_pkg::OFS_FLAGS, 8'hFF);
      bus_r(crs_pkg::OFS_FLAGS);
      chk(rd, 8'h1F);
      @(posedge clk) mem_busy_bit <= 1'b1;
      @(posedge clk);
      #1;
      chk(flag_word[crs_pkg::FL_R], 1'b1);
      @(posedge clk) mem_busy_bit <= 1'b0;
      bus_w(crs_pkg::OFS_SP, 8'h0F);
      bus_w(crs_pkg::OFS_FLAGS, 8'h00);
      step(crs_pkg::CRS_OP_LOAD, 8'h00, 3'h0, 8'h00, 8'h04);
      step(crs_pkg::CRS_OP_LOAD, 8'h80, 3'h0, 8'h80, 8'h08);
      step(crs_pkg::CRS_OP_LOAD, 8'h0F, 3'h0, 8'h0F, 8'h00);
      step(crs_pkg::CRS_OP_ADC, 8'h01, 3'h0, 8'h10, 8'h02);
      step(crs_pkg::CRS_OP_ADC, 8'hF0, 3'h0, 8'h00, 8'h05);
      step(crs_pkg::CRS_OP_SUBC, 8'h01, 3'h0, 8'hFE, 8'h0B);
      step(crs_pkg::CRS_OP_AND, 8'h0F, 3'h0, 8'h0E, 8'h03);
      step(crs_pkg::CRS_OP_XOR, 8'h0E, 3'h0, 8'h00, 8'h07);
      step(crs_pkg::CRS_OP_CLR_C, 8'h00, 3'h0, 8'h00, 8'h06);
      step(crs_pkg::CRS_OP_LOAD, 8'h81, 3'h0, 8'h81, 8'h0A);
      step(crs_pkg::CRS_OP_RLC, 8'h00, 3'h0, 8'h02, 8'h03);
      step(crs_pkg::CRS_OP_RRC, 8'h00, 3'h0, 8'h81, 8'h0A);
      step(crs_pkg::CRS_OP_TOGGLE_CARRY, 8'h00, 3'h0, 8'h81, 8'h0B);
      step(crs_pkg::CRS_OP_TOGGLE_CARRY, 8'h00, 3'h0, 8'h81, 8'h0A);
      step(crs_pkg::CRS_OP_SET_C, 8'h00, 3'h0, 8'h81, 8'h0B);
      step(crs_pkg::CRS_OP_LDC, 8'h04, 3'h3, 8'h81, 8'h0A);
      step(crs_pkg::CRS_OP_LDC, 8'h04, 3'h2, 8'h81, 8'h0B);
      step(crs_pkg::CRS_OP_SET_G, 8'h00, 3'h0, 8'h81, 8'h1B);
      step(crs_pkg::CRS_OP_CLR_G, 8'h00, 3'h0, 8'h81, 8'h0B);
      run_op(crs_pkg::CRS_OP_LOAD_TP, 8'h10, 10'h000, 3'h0);
      run_op(crs_pkg::CRS_OP_STORE_X, 8'h05, 10'h000, 3'h0);
      chk({index_bus.we, index_bus.addr, index_bus.wdata}, {1'b1, 12'h015, 8'h81});
      run_op(crs_pkg::CRS_OP_LOAD_TP, 8'h10, 10'h004, 3'h0);
      run_op(crs_pkg::CRS_OP_INDEX, 8'h05, 10'h000, 3'h0);
      chk(index_bus.addr, 12'hC15);
      run_op(crs_pkg::CRS_OP_STORE_X, 8'h05, 10'h000, 3'h0);
      chk(index_bus.we, 1'b0);
      bus_r(crs_pkg::OFS_TP_HI);
      chk(rd[2:0], 3'h0);
      run_op(crs_pkg::CRS_OP_JUMP, 8'h00, 10'h2AB, 3'h0);
      push_log.delete();
      @(posedge clk) cmd <= '{op: crs_pkg::CRS_OP_CALL, operand: 8'h00, target: 10'h155,
                              bit_sel: 3'h0};
      @(posedge clk) cmd <= '{op: crs_pkg::CRS_OP_JUMP, operand: 8'h00, target: 10'h3FF,
                              bit_sel: 3'h0};
      @(posedge clk) cmd <= '0;
      #1;
      wait_idle();
      @(posedge clk);
      #1;
      chk(instr_pointer, 10'h155);
      chk(stack_top_index, 4'hD);
      chk(push_log.size(), 16'h0002);
      chk(push_log[0], 16'h3FAB);
      chk(push_log[1], 16'h3E02);
      run_op(crs_pkg::CRS_OP_RET, 8'h00, 10'h000, 3'h0);
      wait_idle();
      chk(instr_pointer, 10'h2AB);
      chk(stack_top_index, 4'hF);
      print_verdict();
   end
endmodule : tb_crs_register_set
